/* hw/spl_pkg.sv */
// Constants, types and the region decoder for the sector protection logic.
// Assumes a single 50 MHz clock and a command decoder in front of the port.
//
// Overview of operation
// (R1) Bottom parameter select: top sectors own pairs
// (R2) Top parameter select: bottom sectors own pairs
// (R3) Program clears one persistent bit; erase sets all
// (R4) Persistent erase is global, takes no address
// (R5) Program and erase take time, busy readable
// (R6) Array reads refused while persistent program runs
// (R7) Host reads a region at byte zero
// (R8) Persistent bits delivered erased to one
// (R9) Dynamic bit written to zero or one freely
// (R10) Unprotected only when both bits are one
// (R11) Volatile lock bit guards all persistent bits
// (R12) Locked: persistent program or erase fails, no change
// (R13) Persistent mode: reset sets lock, no command can
// (R14) Password mode: reset clears lock, unlock sets
// (R15) Host clears lock after configuring persistent bits
// (R16) Software reset leaves lock unchanged
// (R17) Any reset returns dynamic bits to unprotected
// (R18) Program or erase refused where either bit zero
// (R19) Busy spans every persistent command, even rejected
package spl_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned NS_PER_US      = 1000;
	localparam int unsigned CYC_PER_US     = NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned REJECT_TIME_US = 1;
	localparam int unsigned US_W           = 20;

	// ****************************************
	// Array geometry
	// ****************************************
	localparam int unsigned ADDR_W          = 25;
	localparam int unsigned IDX_W           = 10;
	localparam int unsigned NUM_REGIONS     = 542;
	localparam logic [8:0]  TOP_PARAM_BLOCK = 9'h1_FE;
	localparam logic [8:0]  BOT_PARAM_END   = 9'h0_02;
	localparam logic [9:0]  TOP_SECT_BASE   = 10'h1_FE;
	localparam logic [9:0]  BOT_BLOCK_SHIFT = 10'h0_1E;

	// ****************************************
	// Register map
	// ****************************************
	localparam int unsigned REG_AW       = 8;
	localparam logic [7:0]  OFF_CMD      = 8'h0_0;
	localparam logic [7:0]  OFF_ADDR     = 8'h0_4;
	localparam logic [7:0]  OFF_STATUS   = 8'h0_8;
	localparam int unsigned CMD_OP_LSB   = 0;
	localparam int unsigned CMD_DYN_BIT  = 8;
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_LOCK_BIT  = 1;
	localparam int unsigned ST_FAIL_BIT  = 2;
	localparam int unsigned ST_PERS_BIT  = 3;
	localparam int unsigned ST_DYN_BIT   = 4;
	localparam int unsigned ST_PROT_BIT  = 5;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_PERS_PROG,
		OP_PERS_ERASE,
		OP_DYN_WRITE,
		OP_CLEAR_LOCK,
		OP_SOFT_RESET
	} spl_op_e;

	// Byte address to protection pair index; low address bits are ignored
	function automatic logic [IDX_W-1:0] spl_region_index(input logic [ADDR_W-1:0] a,
		input logic top_bottom_param_select);
		logic [8:0] blk;
		logic [4:0] sec;
		blk = a[24:16];
		sec = a[16:12];
		if (!top_bottom_param_select) begin
			if (blk < TOP_PARAM_BLOCK) begin
				return {1'b0, blk};
			end
			return TOP_SECT_BASE + {5'b0_0000, sec};
		end
		if (blk < BOT_PARAM_END) begin
			return {5'b0_0000, sec};
		end
		return {1'b0, blk} + BOT_BLOCK_SHIFT;
	endfunction

endpackage

/* hw/spl_tmr_if.sv */
// Handshake between the protection state machine and its operation timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface spl_tmr_if;
	import spl_pkg::*;
	logic            start;
	logic [US_W-1:0] len_us;
	logic            busy;
	logic            done;
	modport ctl (output start, output len_us, input busy, input done);
	modport tmr (input start, input len_us, output busy, output done);
endinterface

/* hw/spl_op_timer.sv */
// Microsecond operation timer with a one-cycle tick enable from a divider.
// Assumes len_us is at least one when start pulses.
`timescale 1ns/1ps
module spl_op_timer
	import spl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	spl_tmr_if.tmr    t
);

	logic [7:0]      div;
	logic [US_W-1:0] us_left;
	logic            tick;

	assign tick = t.busy && (div == 8'(CYC_PER_US - 1));

	// ****************************************
	// Divider, only runs while an operation is timed
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div <= 8'h0_0;
		end else if (t.start || tick || !t.busy) begin
			div <= 8'h0_0;
		end else begin
			div <= div + 8'h0_1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			t.busy  <= 1'b0;
			t.done  <= 1'b0;
			us_left <= '0;
		end else begin
			t.done <= 1'b0;
			if (t.start) begin
				t.busy  <= 1'b1; // R5
				us_left <= t.len_us;
			end else if (tick) begin
				if (us_left <= US_W'(1)) begin
					t.busy <= 1'b0;
					t.done <= 1'b1;
				end else begin
					us_left <= us_left - US_W'(1);
				end
			end
		end
	end

	a_done_ends_busy: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		t.done |-> !t.busy && $past(t.busy)) else $error("done without busy ending");

endmodule

/* hw/spl_sector_protect.sv */
// Protection state of every region: persistent bits, dynamic bits, guard lock.
// Assumes a command decoder drives the register port and the check port,
// and that password comparison happens outside and reports success.
`timescale 1ns/1ps
module spl_sector_protect
	import spl_pkg::*;
#(
	parameter int unsigned PROG_TIME_US  = 200,
	parameter int unsigned ERASE_TIME_US = 50000
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              top_bottom_param_select_i,
	input  wire logic              password_mode_i,
	input  wire logic              password_unlock_ok_i,
	input  wire logic [REG_AW-1:0] reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [31:0]       reg_rdata_o,
	input  wire logic [ADDR_W-1:0] check_addr_i,
	output logic                   check_protected_o,
	output logic                   array_read_block_o,
	output logic                   busy_o,
	output logic                   persistent_guard_lock_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PROG,
		ST_ERASE,
		ST_REJECT
	} spl_state_e;

	spl_state_e             state;
	logic [NUM_REGIONS-1:0] persistent_protect_bit = '1; // R8
	logic [NUM_REGIONS-1:0] dynamic_protect_bit;
	logic                   persistent_guard_lock;
	logic                   init_pending;
	logic                   fail;
	logic [ADDR_W-1:0]      region_addr;
	logic [IDX_W-1:0]       prog_idx;
	logic [IDX_W-1:0]       addr_idx;
	logic [IDX_W-1:0]       check_idx;
	logic                   lock_open;
	logic                   cmd_wr;
	spl_op_e                cmd_op;
	logic                   pers_cmd;
	logic                   cmd_accept;
	logic                   fail_clr;

	spl_tmr_if tmr ();

	spl_op_timer u_timer (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.t     (tmr)
	);

	// ****************************************
	// Command decode
	// ****************************************
	assign addr_idx   = spl_region_index(region_addr, top_bottom_param_select_i); // R1 R2
	assign check_idx  = spl_region_index(check_addr_i, top_bottom_param_select_i); // R1 R2
	assign lock_open  = persistent_guard_lock && !init_pending;
	assign cmd_wr     = reg_wr_i && (reg_addr_i == OFF_CMD);
	assign cmd_op     = spl_op_e'(reg_wdata_i[CMD_OP_LSB +: 3]);
	assign pers_cmd   = (cmd_op == OP_PERS_PROG) || (cmd_op == OP_PERS_ERASE);
	// Commands that arrive while an operation runs are dropped, not queued
	assign cmd_accept = cmd_wr && (state == ST_IDLE);
	assign fail_clr   = reg_wr_i && (reg_addr_i == OFF_STATUS) && reg_wdata_i[ST_FAIL_BIT];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			region_addr <= '0;
		end else if (reg_wr_i && (reg_addr_i == OFF_ADDR)) begin
			region_addr <= reg_wdata_i[ADDR_W-1:0]; // R7
		end
	end

	// ****************************************
	// Operation sequencer
	// ****************************************
	always_comb begin
		tmr.start  = 1'b0;
		tmr.len_us = US_W'(REJECT_TIME_US);
		if (cmd_accept && pers_cmd) begin
			tmr.start = 1'b1; // R19
			if (!lock_open) begin
				tmr.len_us = US_W'(REJECT_TIME_US); // R12
			end else if (cmd_op == OP_PERS_PROG) begin
				tmr.len_us = US_W'(PROG_TIME_US); // R5
			end else begin
				tmr.len_us = US_W'(ERASE_TIME_US); // R5
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state    <= ST_IDLE;
			prog_idx <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (cmd_accept && pers_cmd) begin
						if (!lock_open) begin
							state <= ST_REJECT; // R12
						end else if (cmd_op == OP_PERS_PROG) begin
							state    <= ST_PROG;
							prog_idx <= addr_idx;
						end else begin
							state <= ST_ERASE; // R4
						end
					end
				end
				ST_PROG, ST_ERASE, ST_REJECT: begin
					if (tmr.done) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Persistent bits
	// ****************************************
	// Non-volatile, so no reset touches them; they start erased
	always_ff @(posedge clk_i) begin
		if (tmr.done && (state == ST_PROG)) begin
			persistent_protect_bit[prog_idx] <= 1'b0; // R3
		end else if (tmr.done && (state == ST_ERASE)) begin
			persistent_protect_bit <= '1; // R3 R4
		end
	end

	// ****************************************
	// Dynamic bits
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dynamic_protect_bit <= '1; // R17
		end else if (cmd_accept && (cmd_op == OP_SOFT_RESET)) begin
			dynamic_protect_bit <= '1; // R17
		end else if (cmd_accept && (cmd_op == OP_DYN_WRITE)) begin
			dynamic_protect_bit[addr_idx] <= reg_wdata_i[CMD_DYN_BIT]; // R9
		end
	end

	// ****************************************
	// Guard lock
	// ****************************************
	// Reset loads a constant; the mode strap is applied one edge later
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			init_pending <= 1'b1;
		end else begin
			init_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			persistent_guard_lock <= 1'b1; // R13
		end else if (init_pending) begin
			persistent_guard_lock <= !password_mode_i; // R13 R14
		end else if (password_mode_i && password_unlock_ok_i) begin
			persistent_guard_lock <= 1'b1; // R14
		end else if (cmd_accept && (cmd_op == OP_CLEAR_LOCK)) begin
			persistent_guard_lock <= 1'b0; // R11
		end
	end

	// ****************************************
	// Failure flag, set wins over clear
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fail <= 1'b0;
		end else if (cmd_accept && pers_cmd && !lock_open) begin
			fail <= 1'b1; // R12
		end else if (fail_clr) begin
			fail <= 1'b0;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			check_protected_o <= 1'b0;
		end else begin
			check_protected_o <= !(persistent_protect_bit[check_idx]
				&& dynamic_protect_bit[check_idx]); // R10 R18
		end
	end

	assign array_read_block_o      = (state == ST_PROG); // R6
	assign busy_o                  = (state != ST_IDLE); // R19
	assign persistent_guard_lock_o = lock_open;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i && (reg_addr_i == OFF_ADDR)) begin
			reg_rdata_o <= {{(32 - ADDR_W){1'b0}}, region_addr};
		end else if (reg_rd_i && (reg_addr_i == OFF_STATUS)) begin
			reg_rdata_o <= '0;
			reg_rdata_o[ST_BUSY_BIT] <= busy_o; // R5
			reg_rdata_o[ST_LOCK_BIT] <= lock_open;
			reg_rdata_o[ST_FAIL_BIT] <= fail;
			reg_rdata_o[ST_PERS_BIT] <= persistent_protect_bit[addr_idx];
			reg_rdata_o[ST_DYN_BIT]  <= dynamic_protect_bit[addr_idx];
			reg_rdata_o[ST_PROT_BIT] <= !(persistent_protect_bit[addr_idx]
				&& dynamic_protect_bit[addr_idx]); // R10
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_lock_no_rise: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		$rose(persistent_guard_lock) |-> $past(init_pending)
		|| $past(password_mode_i && password_unlock_ok_i)) else $error("lock rose");

	a_locked_cmd_fails: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		cmd_accept && pers_cmd && !lock_open |=> state == ST_REJECT && fail
		&& $stable(persistent_protect_bit)) else $error("locked command ran");

	a_lock_freezes_bits: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		!lock_open |=> $stable(persistent_protect_bit))
		else $error("frozen bit changed");

	a_erase_all_ones: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		tmr.done && state == ST_ERASE |=> &persistent_protect_bit)
		else $error("erase left a zero");

	a_prog_clears_bit: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		tmr.done && state == ST_PROG |=> !persistent_protect_bit[$past(prog_idx)])
		else $error("program missed");

	a_soft_keeps_lock: assert property (@(posedge clk_i) disable iff (rst_i) // R16
		cmd_accept && cmd_op == OP_SOFT_RESET && !init_pending && !password_unlock_ok_i
		|=> $stable(persistent_guard_lock) && &dynamic_protect_bit)
		else $error("soft reset misbehaved");

	a_soft_frees_dyn: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		cmd_accept && cmd_op == OP_SOFT_RESET |=> &dynamic_protect_bit)
		else $error("soft reset kept a dynamic lock");

	a_dyn_write_value: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		cmd_accept && cmd_op == OP_DYN_WRITE
		|=> dynamic_protect_bit[$past(addr_idx)] == $past(reg_wdata_i[CMD_DYN_BIT]))
		else $error("dynamic write lost");

	// Release edge skipped: the flop still shows its reset value there
	a_check_protect: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		$past(!rst_i) |-> check_protected_o == !($past(persistent_protect_bit[check_idx])
		&& $past(dynamic_protect_bit[check_idx]))) else $error("protect wrong");

	a_busy_on_start: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		cmd_accept && pers_cmd |=> (busy_o && tmr.busy) [*2])
		else $error("busy missing");

	// One microsecond of reject time, counted in clocks of the divider
	a_reject_busy_len: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		cmd_accept && pers_cmd && !lock_open |=> busy_o [*8] ##43 busy_o ##1 !busy_o)
		else $error("reject busy length wrong");

	a_done_idle: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		tmr.done |=> !busy_o) else $error("busy outlived operation");

	a_read_block: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		array_read_block_o |-> tmr.busy || tmr.done) else $error("read block idle");

	// Busy must stay visible to software while an operation runs
	a_busy_status: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		reg_rd_i && reg_addr_i == OFF_STATUS |=> reg_rdata_o[ST_BUSY_BIT] == $past(busy_o))
		else $error("busy not readable");

	a_status_protect: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		reg_rd_i && reg_addr_i == OFF_STATUS |=> reg_rdata_o[ST_PROT_BIT]
		== !(reg_rdata_o[ST_PERS_BIT] && reg_rdata_o[ST_DYN_BIT])) else $error("protect bit wrong");

	// Sticky so software sees a rejection after busy has dropped
	a_fail_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		fail && !fail_clr |=> fail)
		else $error("fail flag lost");

	a_init_lock_mode: assert property (@(posedge clk_i) disable iff (rst_i) // R13 R14
		init_pending && !rst_i |=> persistent_guard_lock == !$past(password_mode_i))
		else $error("lock not set by reset");

	a_unlock_sets_lock: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		password_mode_i && password_unlock_ok_i && !init_pending |=> persistent_guard_lock)
		else $error("unlock ignored");

endmodule

/* verif/spl_host_model.sv */
// Host controller model that issues protection commands over the register port.
// Assumes a single clock shared with the protection block.
`timescale 1ns/1ps
module spl_host_model
	import spl_pkg::*;
(
	input  wire logic              clk_i,
	output logic      [REG_AW-1:0] reg_addr_o,
	output logic      [31:0]       reg_wdata_o,
	output logic                   reg_wr_o,
	output logic                   reg_rd_o,
	input  wire logic [31:0]       reg_rdata_i
);

	// ****************************************
	// Bus cycles
	// ****************************************
	initial begin
		reg_addr_o  = 8'h00;
		reg_wdata_o = 32'h0000_0000;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
	end

	// Released lines flip so a stale value is never mistaken for a live one
	task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		@(posedge clk_i);
		reg_wr_o    <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~d;
		#1;
	endtask

	task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
		#1;
		d = reg_rdata_i;
	endtask

	// ****************************************
	// Protection commands
	// ****************************************
	task automatic set_addr(input logic [ADDR_W-1:0] a);
		wr(OFF_ADDR, {7'h00, a & 25'h1FF_F000});
	endtask

	// Call only once every persistent bit holds its final value
	task automatic clear_lock();
		wr(OFF_CMD, 32'(OP_CLEAR_LOCK));
	endtask

endmodule

/* verif/spl_sector_protect_tb.sv */
// Self-checking bench for the sector protection logic.
// Assumes short operation times so persistent commands end within about 150 cycles.
`timescale 1ns/1ps
module spl_sector_protect_tb
	import spl_pkg::*;
;

	logic              clk_i;
	logic              rst_i;
	logic              tbs;
	logic              pwm;
	logic              unl;
	logic [ADDR_W-1:0] caddr;
	logic [REG_AW-1:0] ra;
	logic [31:0]       wd;
	logic              wr;
	logic              rd;
	logic [31:0]       rdat;
	logic              prot;
	logic              arb;
	logic              busy;
	logic              lock;
	int                err_count;
	int                compares;

	spl_sector_protect #(.PROG_TIME_US(2), .ERASE_TIME_US(3)) i_spl_sector_protect (
		.clk_i                     (clk_i),
		.rst_i                     (rst_i),
		.top_bottom_param_select_i (tbs),
		.password_mode_i           (pwm),
		.password_unlock_ok_i      (unl),
		.reg_addr_i                (ra),
		.reg_wdata_i               (wd),
		.reg_wr_i                  (wr),
		.reg_rd_i                  (rd),
		.reg_rdata_o               (rdat),
		.check_addr_i              (caddr),
		.check_protected_o         (prot),
		.array_read_block_o        (arb),
		.busy_o                    (busy),
		.persistent_guard_lock_o   (lock)
	);

	spl_host_model i_spl_host_model (
		.clk_i       (clk_i),
		.reg_addr_o  (ra),
		.reg_wdata_o (wd),
		.reg_wr_o    (wr),
		.reg_rd_o    (rd),
		.reg_rdata_i (rdat)
	);

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] st(input logic b, l, f, p, d);
		return {26'h0, ~(p & d), d, p, f, l, b};
	endfunction

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic reg_chk(input logic [REG_AW-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		i_spl_host_model.rd(a, d);
		chk(d, e);
	endtask

	task automatic status(input logic [31:0] e);
		reg_chk(OFF_STATUS, e);
	endtask

	task automatic cmd(input spl_op_e op, input logic val);
		i_spl_host_model.wr(OFF_CMD, {23'h00_0000, val, 5'h00, op});
	endtask

	task automatic probe(input logic [ADDR_W-1:0] a, input logic e);
		@(posedge clk_i);
		caddr <= a;
		repeat (2) @(posedge clk_i);
		#1;
		chk({31'h0, prot}, {31'h0, e});
	endtask

	// Bounded so a stuck busy ends the run instead of hanging it
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy === 1'b1 && n < 2000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (busy !== 1'b0) begin
			chk({31'h0, busy}, 32'h0000_0000);
			results();
		end
	endtask

	task automatic hw_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		results();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		rst_i     = 1'b1;
		tbs       = 1'b0;
		pwm       = 1'b0;
		unl       = 1'b0;
		caddr     = 25'h000_0000;
		err_count = 0;
		compares  = 0;
		hw_reset();
		i_spl_host_model.set_addr(25'h1FE_1000);
		status(st(0, 1, 0, 1, 1));
		reg_chk(OFF_ADDR, 32'h01FE_1000);
		$display("Test reset state done");
		cmd(OP_DYN_WRITE, 1'b0);
		status(st(0, 1, 0, 1, 0));
		probe(25'h1FE_1000, 1'b1);
		probe(25'h1FE_0000, 1'b0);
		cmd(OP_DYN_WRITE, 1'b1);
		status(st(0, 1, 0, 1, 1));
		$display("Test dynamic bits done");
		cmd(OP_PERS_PROG, 1'b0);
		chk({31'h0, busy}, 32'h0000_0001);
		chk({31'h0, arb}, 32'h0000_0001);
		status(st(1, 1, 0, 1, 1));
		wait_idle();
		chk({31'h0, arb}, 32'h0000_0000);
		status(st(0, 1, 0, 0, 1));
		probe(25'h1FE_1000, 1'b1);
		probe(25'h1FE_0000, 1'b0);
		@(posedge clk_i);
		tbs <= 1'b1;
		probe(25'h1E1_0000, 1'b1);
		probe(25'h1E0_0000, 1'b0);
		probe(25'h001_F000, 1'b0);
		@(posedge clk_i);
		tbs <= 1'b0;
		$display("Test persistent program done");
		// Address left elsewhere on purpose: erase must ignore it
		i_spl_host_model.set_addr(25'h000_0000);
		cmd(OP_PERS_ERASE, 1'b0);
		chk({31'h0, busy}, 32'h0000_0001);
		wait_idle();
		i_spl_host_model.set_addr(25'h1FE_1000);
		status(st(0, 1, 0, 1, 1));
		$display("Test persistent erase done");
		cmd(OP_DYN_WRITE, 1'b0);
		cmd(OP_SOFT_RESET, 1'b0);
		status(st(0, 1, 0, 1, 1));
		$display("Test soft reset done");
		i_spl_host_model.clear_lock();
		chk({31'h0, lock}, 32'h0000_0000);
		cmd(OP_PERS_PROG, 1'b0);
		chk({31'h0, busy}, 32'h0000_0001);
		wait_idle();
		status(st(0, 0, 1, 1, 1));
		@(posedge clk_i);
		unl <= 1'b1;
		@(posedge clk_i);
		unl <= 1'b0;
		#1;
		chk({31'h0, lock}, 32'h0000_0000);
		i_spl_host_model.wr(OFF_STATUS, 32'h0000_0004);
		cmd(OP_SOFT_RESET, 1'b0);
		status(st(0, 0, 0, 1, 1));
		hw_reset();
		chk({31'h0, lock}, 32'h0000_0001);
		$display("Test guard lock done");
		@(posedge clk_i);
		pwm <= 1'b1;
		hw_reset();
		chk({31'h0, lock}, 32'h0000_0000);
		@(posedge clk_i);
		unl <= 1'b1;
		@(posedge clk_i);
		unl <= 1'b0;
		#1;
		chk({31'h0, lock}, 32'h0000_0001);
		$display("Test password mode done");
		results();
	end

endmodule
